// [pkg/fspc_pkg.sv]
// constants, carrier structs and state type for the flash self-program controller
package fspc_pkg;

    // command field of the self-program control register
    localparam int          CMD_W       = 5;
    localparam int          RSVD_W      = 3;
    localparam int          BIT_EN      = 0;
    localparam int          BIT_ERASE   = 1;
    localparam int          BIT_WRITE   = 2;
    localparam int          BIT_READ_FUSE_LOCK_BIT    = 3;
    localparam int          BIT_CLEAR_PAGE_BUFFER_BIT    = 4;
    localparam logic [4:0]  CMD_IDLE    = 5'h00;
    localparam logic [4:0]  PAT_LOAD    = 5'h01;
    localparam logic [4:0]  PAT_ERASE   = 5'h03;
    localparam logic [4:0]  PAT_WRITE   = 5'h05;
    localparam logic [4:0]  PAT_READ_FUSE_LOCK_BIT    = 5'h09;
    localparam logic [4:0]  PAT_CLEAR_PAGE_BUFFER_BIT    = 5'h11;
    localparam logic [2:0]  RSVD_READ   = 3'h0;

    // arming windows in clock cycles
    localparam logic [2:0]  ARM_CYCLES  = 3'h4;
    localparam logic [2:0]  LPM_CYCLES  = 3'h3;

    // flash write time, figures in ns, counts derived from the clock rate
    localparam longint      CLK_HZ        = 125_000_000;
    localparam longint      NS_PER_S      = 1_000_000_000;
    localparam longint      WRITE_MIN_NS  = 3_700_000;
    localparam longint      WRITE_MAX_NS  = 4_500_000;
    localparam longint      WRITE_MIN_CYC = (WRITE_MIN_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
    localparam longint      WRITE_MAX_CYC = (WRITE_MAX_NS * CLK_HZ) / NS_PER_S;

    // readback selection by pointer low bits
    localparam logic [1:0]  ZSEL_FUSE_LOW  = 2'h0;
    localparam logic [1:0]  ZSEL_LOCK      = 2'h1;
    localparam logic [1:0]  ZSEL_FUSE_EXT  = 2'h2;
    localparam logic [1:0]  ZSEL_FUSE_HIGH = 2'h3;

    // lock bits {high, low}; one is unprogrammed
    localparam logic [1:0]  LOCK_ERASED = 2'h3;
    localparam logic [1:0]  LOCK_MODE3  = 2'h0;
    localparam int          LOCK_LOW    = 0;
    localparam logic [5:0]  LOCK_PAD    = 6'h3f;

    // erased flash / buffer word
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam int          FADDR_W     = 15;

    // command towards the flash array
    typedef struct packed {
        logic                erase;
        logic                prog;
        logic [FADDR_W-1:0]  addr;
        logic [15:0]         wdata;
    } fspc_flash_cmd_t;

    // store-program instruction operands
    typedef struct packed {
        logic [15:0] z;
        logic [15:0] data;
    } fspc_spm_req_t;

    // protection levels handed to the external programming logic
    typedef struct packed {
        logic prog_block;
        logic verify_block;
        logic fuse_lock;
        logic debug_read_ok;
    } fspc_lock_ctl_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_STREAM, ST_BUSY} fspc_state_t;

endpackage

// [rtl/fspc_wtimer.sv]
// flash write duration timer
`timescale 1ns/10ps
module fspc_wtimer #(
    parameter int unsigned CYCLES = 462500
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // control
    input  wire logic start_in,
    // status
    output logic      busy_out,
    output logic      done_out
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);
    localparam logic [CNT_W-1:0] ZERO = '0;

    logic [CNT_W-1:0] cnt_q;

    // down counter; done fires on the last cycle of the operation
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q    <= ZERO;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in && !busy_out) begin
            cnt_q    <= LOAD;
            busy_out <= 1'b1;
            done_out <= 1'b0;
        end else if (busy_out) begin
            cnt_q    <= cnt_q - 1'b1;
            done_out <= (cnt_q == CNT_W'(1));
            busy_out <= (cnt_q != ZERO);
        end else begin
            done_out <= 1'b0;
        end
    end
endmodule

// [rtl/fspc_ctrl.sv]
// flash self-program controller: command arming, page buffer, erase/write sequencing, lock bits
`timescale 1ns/10ps
module fspc_ctrl #(
    parameter int unsigned PAGE_WORDS   = 32,
    parameter int unsigned WRITE_CYCLES = 32'(fspc_pkg::WRITE_MIN_CYC)
) (
    // clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    // control register access from the core
    input  wire logic                   ctrl_wr_in,
    input  wire logic [7:0]             ctrl_wdata_in,
    output logic [7:0]                  ctrl_rdata_out,
    // instruction strobes from the core
    input  wire logic                   spm_in,
    input  wire logic                   lpm_in,
    input  wire fspc_pkg::fspc_spm_req_t spm_req_in,
    output logic                        lpm_hit_out,
    output logic [7:0]                  lpm_data_out,
    output logic                        cpu_halt_out,
    // fuses, eeprom status, chip erase
    input  wire logic                   self_program_fuse_in,
    input  wire logic                   debug_link_fuse_in,
    input  wire logic [7:0]             fuse_low_in,
    input  wire logic [7:0]             fuse_high_in,
    input  wire logic [7:0]             fuse_ext_in,
    input  wire logic                   eeprom_busy_in,
    input  wire logic                   chip_erase_in,
    // lock bit storage
    input  wire logic [1:0]             lock_nv_in,
    output logic [1:0]                  lock_bits_out,
    output fspc_pkg::fspc_lock_ctl_t    lock_ctl_out,
    // flash array
    output fspc_pkg::fspc_flash_cmd_t   flash_cmd_out
);
    localparam int WORD_W = $clog2(PAGE_WORDS);
    localparam int PAGE_W = fspc_pkg::FADDR_W - WORD_W;
    localparam logic [WORD_W-1:0] LAST_WORD = WORD_W'(PAGE_WORDS - 1);
    localparam logic [WORD_W-1:0] WORD_ZERO = '0;
    localparam logic [2:0]        CNT_ZERO  = 3'h0;
    localparam logic [2:0]        CNT_ONE   = 3'h1;

    // accepted command patterns
    function automatic logic is_valid_pat(input logic [4:0] v);
        return (v == fspc_pkg::PAT_CLEAR_PAGE_BUFFER_BIT) || (v == fspc_pkg::PAT_READ_FUSE_LOCK_BIT) ||
               (v == fspc_pkg::PAT_WRITE) || (v == fspc_pkg::PAT_ERASE) ||
               (v == fspc_pkg::PAT_LOAD);
    endfunction

    // commands that start a timed flash write
    function automatic logic is_timed(input logic [4:0] v);
        return (v == fspc_pkg::PAT_ERASE) || (v == fspc_pkg::PAT_WRITE) ||
               (v == fspc_pkg::PAT_READ_FUSE_LOCK_BIT);
    endfunction

    fspc_pkg::fspc_state_t      state_q;
    logic [4:0]                 cmd_q;
    logic [2:0]                 arm_cnt_q;
    logic [2:0]                 lpm_cnt_q;
    logic [WORD_W-1:0]          idx_q;
    logic [PAGE_W-1:0]          page_q;
    logic [1:0]                 lock_q;
    logic [1:0]                 lock_new_q;
    logic                       lock_loaded_q;
    logic [15:0]                buf_q [PAGE_WORDS];

    logic                       wr_ok;
    logic                       armed;
    logic                       spm_allowed;
    logic                       spm_go;
    logic                       start_op;
    logic                       load_op;
    logic                       lpm_read;
    logic                       buf_clear;
    logic                       tmr_busy;
    logic                       tmr_done;
    logic [WORD_W-1:0]          spm_word;
    logic [PAGE_W-1:0]          spm_page;

    // request decode
    assign armed       = (state_q == fspc_pkg::ST_ARMED);
    assign spm_allowed = !self_program_fuse_in;
    // eeprom writes lock out the control register; busy states refuse new commands
    assign wr_ok       = ctrl_wr_in && !eeprom_busy_in &&
                         ((state_q == fspc_pkg::ST_IDLE) || armed) &&
                         is_valid_pat(ctrl_wdata_in[4:0]);
    assign spm_go      = armed && !wr_ok && spm_in;
    assign start_op    = spm_go && spm_allowed && is_timed(cmd_q);
    assign load_op     = spm_go && spm_allowed && (cmd_q == fspc_pkg::PAT_LOAD);
    assign lpm_read    = armed && !wr_ok && !spm_in && lpm_in &&
                         (cmd_q == fspc_pkg::PAT_READ_FUSE_LOCK_BIT) && (lpm_cnt_q != CNT_ZERO);
    assign spm_word    = spm_req_in.z[WORD_W:1];
    assign spm_page    = spm_req_in.z[fspc_pkg::FADDR_W:WORD_W+1];
    assign buf_clear   = (wr_ok && (ctrl_wdata_in[4:0] == fspc_pkg::PAT_CLEAR_PAGE_BUFFER_BIT)) ||
                         (tmr_done && (cmd_q == fspc_pkg::PAT_WRITE));

    // flash write duration; one timer serves erase, write and lock write
    fspc_wtimer #(
        .CYCLES   (WRITE_CYCLES)
    ) u_wtimer (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .start_in (start_op),
        .busy_out (tmr_busy),
        .done_out (tmr_done)
    );

    // command sequencer and arming windows
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q   <= fspc_pkg::ST_IDLE;
            cmd_q     <= fspc_pkg::CMD_IDLE;
            arm_cnt_q <= CNT_ZERO;
            lpm_cnt_q <= CNT_ZERO;
        end else begin
            unique case (state_q)
                fspc_pkg::ST_IDLE: begin
                    if (wr_ok) begin
                        cmd_q     <= ctrl_wdata_in[4:0];
                        arm_cnt_q <= fspc_pkg::ARM_CYCLES;
                        lpm_cnt_q <= fspc_pkg::LPM_CYCLES;
                        state_q   <= fspc_pkg::ST_ARMED;
                    end
                end
                fspc_pkg::ST_ARMED: begin
                    if (wr_ok) begin
                        // a fresh write restarts the window with the new pattern
                        cmd_q     <= ctrl_wdata_in[4:0];
                        arm_cnt_q <= fspc_pkg::ARM_CYCLES;
                        lpm_cnt_q <= fspc_pkg::LPM_CYCLES;
                    end else if (start_op) begin
                        // command bits stay set as the busy flag
                        state_q <= (cmd_q == fspc_pkg::PAT_WRITE) ?
                                   fspc_pkg::ST_STREAM : fspc_pkg::ST_BUSY;
                    end else if (spm_go || lpm_read) begin
                        cmd_q   <= fspc_pkg::CMD_IDLE;
                        state_q <= fspc_pkg::ST_IDLE;
                    end else if (arm_cnt_q == CNT_ONE) begin
                        cmd_q   <= fspc_pkg::CMD_IDLE;
                        state_q <= fspc_pkg::ST_IDLE;
                    end else begin
                        arm_cnt_q <= arm_cnt_q - CNT_ONE;
                        if (lpm_cnt_q != CNT_ZERO) begin
                            lpm_cnt_q <= lpm_cnt_q - CNT_ONE;
                        end
                    end
                end
                fspc_pkg::ST_STREAM: begin
                    // stream ends long before the timer, so done is never missed
                    if (idx_q == LAST_WORD) begin
                        state_q <= fspc_pkg::ST_BUSY;
                    end
                end
                fspc_pkg::ST_BUSY: begin
                    if (tmr_done) begin
                        cmd_q   <= fspc_pkg::CMD_IDLE;
                        state_q <= fspc_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // page address and stream index
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            page_q <= '0;
            idx_q  <= WORD_ZERO;
        end else if (start_op) begin
            page_q <= spm_page;
            idx_q  <= WORD_ZERO;
        end else if (state_q == fspc_pkg::ST_STREAM) begin
            idx_q  <= idx_q + 1'b1;
        end
    end

    // temporary page buffer; erased word reads all ones
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                buf_q[i] <= fspc_pkg::ERASED_WORD;
            end
        end else if (buf_clear) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                buf_q[i] <= fspc_pkg::ERASED_WORD;
            end
        end else if (load_op) begin
            buf_q[spm_word] <= spm_req_in.data;
        end
    end

    // commands to the flash array; data pair is never used for erase or write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flash_cmd_out <= '0;
        end else begin
            flash_cmd_out.erase <= start_op && (cmd_q == fspc_pkg::PAT_ERASE);
            flash_cmd_out.prog  <= (state_q == fspc_pkg::ST_STREAM);
            if (start_op) begin
                flash_cmd_out.addr  <= {spm_page, WORD_ZERO};
                flash_cmd_out.wdata <= fspc_pkg::ERASED_WORD;
            end else if (state_q == fspc_pkg::ST_STREAM) begin
                flash_cmd_out.addr  <= {page_q, idx_q};
                flash_cmd_out.wdata <= buf_q[idx_q];
            end
        end
    end

    // core halt spans the whole timed erase or write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cpu_halt_out <= 1'b0;
        end else if (start_op && (cmd_q != fspc_pkg::PAT_READ_FUSE_LOCK_BIT)) begin
            cpu_halt_out <= 1'b1;
        end else if (tmr_done) begin
            cpu_halt_out <= 1'b0;
        end
    end

    // lock bits: captured from storage after reset, only lowered by software,
    // raised only by chip erase
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_q        <= fspc_pkg::LOCK_ERASED;
            lock_new_q    <= fspc_pkg::LOCK_ERASED;
            lock_loaded_q <= 1'b0;
        end else begin
            if (!lock_loaded_q) begin
                lock_q        <= lock_nv_in;
                lock_loaded_q <= 1'b1;
            end else if (chip_erase_in) begin
                lock_q <= fspc_pkg::LOCK_ERASED;
            end else if (tmr_busy && tmr_done && (cmd_q == fspc_pkg::PAT_READ_FUSE_LOCK_BIT)) begin
                lock_q <= lock_q & lock_new_q;
            end
            if (start_op && (cmd_q == fspc_pkg::PAT_READ_FUSE_LOCK_BIT)) begin
                lock_new_q <= spm_req_in.data[1:0];
            end
        end
    end

    // protection levels derived from the lock bits and the debug link fuse
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_ctl_out  <= '0;
            lock_bits_out <= fspc_pkg::LOCK_ERASED;
        end else begin
            lock_bits_out              <= lock_q;
            // mode 1 leaves prog_block, verify_block and fuse_lock low
            lock_ctl_out.prog_block    <= !lock_q[fspc_pkg::LOCK_LOW];
            lock_ctl_out.fuse_lock     <= !lock_q[fspc_pkg::LOCK_LOW];
            lock_ctl_out.verify_block  <= (lock_q == fspc_pkg::LOCK_MODE3);
            // readout over the debug link ignores lock bits entirely
            lock_ctl_out.debug_read_ok <= !debug_link_fuse_in;
        end
    end

    // fuse and lock readback through the load instruction
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lpm_hit_out  <= 1'b0;
            lpm_data_out <= 8'h00;
        end else begin
            lpm_hit_out <= lpm_read;
            if (lpm_read) begin
                unique case (spm_req_in.z[1:0])
                    fspc_pkg::ZSEL_FUSE_LOW:  lpm_data_out <= fuse_low_in;
                    fspc_pkg::ZSEL_LOCK:      lpm_data_out <= {fspc_pkg::LOCK_PAD, lock_q};
                    fspc_pkg::ZSEL_FUSE_EXT:  lpm_data_out <= fuse_ext_in;
                    fspc_pkg::ZSEL_FUSE_HIGH: lpm_data_out <= fuse_high_in;
                endcase
            end
        end
    end

    // control register readback, one cycle behind the command bits
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_rdata_out <= 8'h00;
        end else begin
            ctrl_rdata_out <= {fspc_pkg::RSVD_READ, cmd_q};
        end
    end

endmodule

// [sim/fspc_core_model.sv]
// processor core model issuing register writes and program instructions
`timescale 1ns/10ps
module fspc_core_model (
    // clock and halt from the controller
    input  wire logic                clk_in,
    input  wire logic                halt_in,
    // requests towards the controller
    output logic                     wr_out,
    output logic [7:0]               wdata_out,
    output logic                     spm_out,
    output logic                     lpm_out,
    output fspc_pkg::fspc_spm_req_t  req_out
);
    // idle request lines at time zero
    initial begin
        wr_out = 1'b0;
        wdata_out = 8'h00;
        spm_out = 1'b0;
        lpm_out = 1'b0;
        req_out = '0;
    end
    // register write: one cycle, never while the core stands halted
    task automatic cmd(input logic [7:0] v);
        @(negedge clk_in);
        while (halt_in) @(negedge clk_in);
        wr_out = 1'b1;
        wdata_out = v;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~v;
    endtask
    // store or load instruction in the cycle after the write
    task automatic instr(input logic is_spm, input logic [15:0] z, input logic [15:0] d);
        req_out = {z, d};
        spm_out = is_spm;
        lpm_out = !is_spm;
        @(negedge clk_in);
        spm_out = 1'b0;
        lpm_out = 1'b0;
        req_out = ~req_out; // operands no longer valid, so show garbage
    endtask
endmodule

// [sim/fspc_ctrl_props.sv]
// assertion checker for the flash self-program controller ports
`timescale 1ns/10ps
module fspc_ctrl_props #(
    parameter int unsigned PAGE_WORDS   = 32,
    parameter int unsigned WRITE_CYCLES = 64
) (
    // clock, reset and core side
    input wire logic                      clk_in,
    input wire logic                      rst_in,
    input wire logic                      ctrl_wr_in,
    input wire logic [7:0]                ctrl_wdata_in,
    input wire logic [7:0]                ctrl_rdata_out,
    input wire logic                      spm_in,
    input wire logic                      lpm_in,
    input wire fspc_pkg::fspc_spm_req_t   spm_req_in,
    input wire logic                      lpm_hit_out,
    input wire logic [7:0]                lpm_data_out,
    input wire logic                      cpu_halt_out,
    // fuses, locks and flash
    input wire logic                      self_program_fuse_in,
    input wire logic                      debug_link_fuse_in,
    input wire logic                      eeprom_busy_in,
    input wire logic                      chip_erase_in,
    input wire logic [1:0]                lock_bits_out,
    input wire fspc_pkg::fspc_lock_ctl_t  lock_ctl_out,
    input wire fspc_pkg::fspc_flash_cmd_t flash_cmd_out
);
    localparam int HMIN = WRITE_CYCLES - 2;
    localparam int HMAX = WRITE_CYCLES;
    logic [15:0] halt_n_q;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // length of the current halt, zero when running
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in) halt_n_q <= 16'h0;
        else halt_n_q <= cpu_halt_out ? halt_n_q + 16'h1 : 16'h0;
    // accepted arming of a load, erase or write from idle
    sequence arm_s;
        ctrl_wr_in && !eeprom_busy_in && ctrl_wdata_in[4:0] inside {5'h01, 5'h03, 5'h05}
            && ctrl_rdata_out == 8'h00 && !cpu_halt_out;
    endsequence
    sequence quiet_s;
        (!spm_in && !ctrl_wr_in)[*4];
    endsequence
    rsvd_zero_a: assert property (ctrl_rdata_out[7:5] == 3'h0) else $error("reserved bits read nonzero");
    halt_span_a: assert property ($fell(cpu_halt_out) |-> halt_n_q >= HMIN && halt_n_q <= HMAX)
        else $error("halt length off");
    erase_page_a: assert property (flash_cmd_out.erase |-> cpu_halt_out && flash_cmd_out.addr[4:0] == 5'h0)
        else $error("erase address or halt wrong");
    busy_bit_a: assert property (cpu_halt_out |-> ctrl_rdata_out[0]) else $error("enable bit low while busy");
    prog_burst_a: assert property ($rose(flash_cmd_out.prog) |-> (flash_cmd_out.prog && cpu_halt_out)[*8])
        else $error("page write burst broken");
    arm_expire_a: assert property (arm_s ##1 quiet_s |-> ##[1:3] ctrl_rdata_out == 8'h00)
        else $error("arming window did not lapse");
    lpm_lock_a: assert property (lpm_hit_out |-> $past(lpm_in) && ($past(spm_req_in.z[1:0]) != 2'h1
        || lpm_data_out == {6'h3f, lock_bits_out})) else $error("readback wrong");
    lock_free_a: assert property (lock_bits_out == 2'h3 && $past(lock_bits_out, 2) == 2'h3
        |-> !lock_ctl_out.prog_block && !lock_ctl_out.verify_block && !lock_ctl_out.fuse_lock) else $error("mode 1 locked");
    lock_full_a: assert property (lock_bits_out == 2'h0 && $past(lock_bits_out, 2) == 2'h0
        |-> lock_ctl_out.prog_block && lock_ctl_out.verify_block && lock_ctl_out.fuse_lock) else $error("mode 3 open");
    chip_erase_a: assert property (chip_erase_in |-> ##[1:2] lock_bits_out == 2'h3) else $error("locks not erased");
    debug_ok_a: assert property (!debug_link_fuse_in && $past(!debug_link_fuse_in) |=> lock_ctl_out.debug_read_ok)
        else $error("debug readout refused");
    fuse_off_a: assert property (spm_in && self_program_fuse_in && !cpu_halt_out |=> !cpu_halt_out)
        else $error("store ran with fuse off");
endmodule
bind fspc_ctrl fspc_ctrl_props #(.PAGE_WORDS(PAGE_WORDS), .WRITE_CYCLES(WRITE_CYCLES)) u_props (.*);

// [sim/fspc_ctrl_tb.sv]
// self-checking bench for the flash self-program controller
`timescale 1ns/10ps
module fspc_ctrl_tb;
    localparam int unsigned WC = 64;
    logic clk_in = 1'b0, rst_in = 1'b1, self_program_fuse_in = 1'b0, debug_link_fuse_in = 1'b1;
    logic eeprom_busy_in = 1'b0, chip_erase_in = 1'b0, ctrl_wr_in, spm_in, lpm_in, lpm_hit_out, cpu_halt_out;
    logic [7:0] ctrl_wdata_in, ctrl_rdata_out, lpm_data_out, fuse_low_in, fuse_high_in, fuse_ext_in;
    logic [1:0] lock_nv_in = 2'h3, lock_bits_out;
    fspc_pkg::fspc_spm_req_t spm_req_in;
    fspc_pkg::fspc_lock_ctl_t lock_ctl_out;
    fspc_pkg::fspc_flash_cmd_t flash_cmd_out;
    logic [15:0] rnd = 16'h0057, buf_m [32];
    logic [7:0] bad [5] = '{8'h1f, 8'h07, 8'h13, 8'h0f, 8'h0d};
    logic [7:0] rb [4];
    int fail_count = 0, checks = 0;
    logic [31:0] fq [$];
    logic [7:0] lq [$];
    fspc_ctrl #(.PAGE_WORDS(32), .WRITE_CYCLES(WC)) u_dut (.*);
    fspc_core_model u_core (.clk_in(clk_in), .halt_in(cpu_halt_out), .wr_out(ctrl_wr_in), .wdata_out(ctrl_wdata_in),
        .spm_out(spm_in), .lpm_out(lpm_in), .req_out(spm_req_in));
    always #4 clk_in = ~clk_in;
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // bits rise one cycle after the register write, before the spm ends; wait a few cycles, then poll
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(negedge clk_in);
        while (ctrl_rdata_out !== 8'h00 && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        check("idle", n < 300, 1'b1);
    endtask
    task automatic load(input int i);
        buf_m[i] = rnd;
        u_core.cmd(8'h01);
        u_core.instr(1'b1, {10'h0, i[4:0], 1'b1}, rnd);
        rnd = lfsr(rnd);
    endtask
    task automatic page_write(input logic [9:0] p);
        for (int i = 0; i < 32; i++) begin
            fq.push_back({1'b0, p, i[4:0], buf_m[i]});
            buf_m[i] = 16'hffff;
        end
        u_core.cmd(8'h05);
        u_core.instr(1'b1, {p, 6'h00}, rnd);
        wait_idle();
    endtask
    // result watcher: every flash pulse and readback takes the oldest note
    always @(negedge clk_in) begin
        if (flash_cmd_out.erase || flash_cmd_out.prog) begin
            if (fq.size() == 0) check("flash extra", 1'b1, 1'b0);
            else check("flash", {flash_cmd_out.erase, flash_cmd_out.addr,
                flash_cmd_out.erase ? 16'h0 : flash_cmd_out.wdata}, fq.pop_front());
        end
        if (lpm_hit_out) begin
            if (lq.size() == 0) check("lpm extra", 1'b1, 1'b0);
            else check("lpm", lpm_data_out, lq.pop_front());
        end
    end
    // watchdog, far beyond the few hundred cycles needed
    initial begin
        #(8 * 30000);
        fail_count++;
        close_out();
    end
    initial begin
        // random fuse bytes so readback cannot pass by a fixed value
        fuse_low_in = rnd[7:0];
        rnd = lfsr(rnd);
        fuse_high_in = rnd[7:0];
        rnd = lfsr(rnd);
        fuse_ext_in = rnd[7:0];
        rnd = lfsr(rnd);
        foreach (buf_m[i]) buf_m[i] = 16'hffff;
        repeat (5) @(posedge clk_in);
        @(negedge clk_in) rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check("ctrl", ctrl_rdata_out, 8'h00);
        check("locks", lock_bits_out, 2'h3);
        // other patterns have no effect
        foreach (bad[k]) begin
            u_core.cmd(bad[k]);
            repeat (3) @(negedge clk_in);
            check("ignored", ctrl_rdata_out, 8'h00);
        end
        // a valid pattern is refused while the eeprom writes
        eeprom_busy_in = 1'b1;
        u_core.cmd(8'h01);
        repeat (3) @(negedge clk_in);
        check("ee busy", ctrl_rdata_out, 8'h00);
        eeprom_busy_in = 1'b0;
        // reserved bits dropped, window lapses unused
        u_core.cmd(8'he1);
        repeat (2) @(negedge clk_in);
        check("armed", ctrl_rdata_out, 8'h01);
        repeat (5) @(negedge clk_in);
        check("lapsed", ctrl_rdata_out, 8'h00);
        for (int i = 0; i < 32; i++) load(i);
        page_write(rnd[9:0]);
        // clear-buffer in mid fill discards earlier words
        load(3);
        u_core.cmd(8'h11);
        buf_m[3] = 16'hffff;
        repeat (8) @(negedge clk_in);
        load(7);
        page_write(10'h155);
        // erase ignores pointer low bits; fuse off blocks it
        fq.push_back({1'b1, 10'h2aa, 5'h0, 16'h0});
        u_core.cmd(8'h03);
        u_core.instr(1'b1, {10'h2aa, 6'h2b}, rnd);
        wait_idle();
        self_program_fuse_in = 1'b1;
        u_core.cmd(8'h03);
        u_core.instr(1'b1, 16'h0040, rnd);
        repeat (8) @(negedge clk_in);
        self_program_fuse_in = 1'b0;
        // reset in an armed window drops bits and buffer
        load(5);
        u_core.cmd(8'h01);
        lock_nv_in = 2'h2;
        rst_in = 1'b1;
        @(negedge clk_in) rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check("reset", ctrl_rdata_out, 8'h00);
        check("lock load", lock_bits_out, 2'h2);
        buf_m[5] = 16'hffff;
        page_write(10'h001);
        // lock mode 2 by store, then readback of all four bytes
        u_core.cmd(8'h09);
        u_core.instr(1'b1, 16'h0000, 16'hfffe);
        wait_idle();
        check("mode2", {lock_bits_out, lock_ctl_out}, {2'h2, 4'b1010});
        rb = '{fuse_low_in, 8'hfe, fuse_ext_in, fuse_high_in};
        foreach (rb[z]) begin
            lq.push_back(rb[z]);
            u_core.cmd(8'h09);
            u_core.instr(1'b0, 16'(z), rnd);
        end
        u_core.cmd(8'h09);
        u_core.instr(1'b1, 16'h0000, 16'h0000);
        wait_idle();
        debug_link_fuse_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check("mode3", {lock_bits_out, lock_ctl_out}, {2'h0, 4'b1111});
        chip_erase_in = 1'b1;
        @(negedge clk_in) chip_erase_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check("mode1", {lock_bits_out, lock_ctl_out}, {2'h3, 4'b0001});
        check("pending", fq.size() + lq.size(), 32'h0);
        close_out();
    end
endmodule
